// File: cmsr_pkg.sv
// constants and types of the controller mode and interrupt code status block
// assumes a 32-bit axi4-lite slave with byte addresses on 8 bits
package cmsr_pkg;

    // register map
    localparam int             AXI_ADDR_W      = 8;
    localparam int             AXI_DATA_W      = 32;
    localparam logic [7:0]     OFF_CONTROL     = 8'h00;
    localparam logic [7:0]     OFF_STATUS      = 8'h04;

    // axi responses
    localparam logic [1:0]     RESP_OKAY       = 2'h0;
    localparam logic [1:0]     RESP_SLVERR     = 2'h2;

    // field positions, both registers except the abort bit, which is in the control register only
    localparam int             MODE_MSB        = 7;
    localparam int             MODE_LSB        = 5;
    localparam int             ABORT_BIT       = 4;
    localparam int             CODE_MSB        = 3;
    localparam int             CODE_LSB        = 1;
    localparam int             REG_W           = 8;

    // reset values
    localparam logic [2:0]     RST_REQ_MODE    = 3'h4;
    localparam logic [2:0]     RST_WIN_SEL     = 3'h0;

    // interrupt sources, bit i of the pending vector yields code i+1
    localparam int             N_SRC           = 7;
    localparam int             CODE_W          = 3;
    localparam int             SRC_ERR         = 0;
    localparam int             SRC_WAKE        = 6;
    localparam logic [2:0]     CODE_NONE       = 3'h0;
    localparam logic [2:0]     CODE_ERR        = 3'h1;
    localparam logic [2:0]     CODE_TX_TWO     = 3'h2;
    localparam logic [2:0]     CODE_TX_ONE     = 3'h3;
    localparam logic [2:0]     CODE_TX_ZERO    = 3'h4;
    localparam logic [2:0]     CODE_RX_ONE     = 3'h5;
    localparam logic [2:0]     CODE_RX_ZERO    = 3'h6;
    localparam logic [2:0]     CODE_WAKE       = 3'h7;

    // operating modes
    typedef enum logic [2:0] {
        CMSR_MODE_NORMAL  = 3'b000,
        CMSR_MODE_DISABLE = 3'b001,
        CMSR_MODE_LOOP    = 3'b010,
        CMSR_MODE_LISTEN  = 3'b011,
        CMSR_MODE_CONFIG  = 3'b100
    } cmsr_mode_t;

endpackage

// File: cmsr_irq_encoder.sv
// priority encoder from pending interrupt sources to a source code
// assumes pending bits come from logic on the same clock
module cmsr_irq_encoder
    import cmsr_pkg::*;
#(
    parameter int NSRC  = N_SRC,
    parameter int CW    = CODE_W
)
(
    // sources, higher index wins
    input  wire logic [NSRC-1:0] pending,
    // code of the winner, zero when none
    output logic      [CW-1:0]   code
);

    always_comb
    begin
        code = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (pending[i])
            begin
                code = CW'(i + 1);
            end
        end
    end

endmodule

// File: cmsr_status.sv
// can controller mode and interrupt code status with its control register
// assumes an axi4-lite master on clk_sys and same-clock protocol engine signals
//
// Notes on behaviour
// [RULE1] status bits 7-5 show the mode actually in force; reserved codes never appear
// [RULE2] after reset the mode status reads 100, configuration mode
// [RULE3] bits 3-1 show the code of the highest-priority pending interrupt source
// [RULE4] codes: wake 111, rx0 110, rx1 101, tx0 100, tx1 011, tx2 010
// [RULE5] error alone reads 001; nothing pending reads 000
// [RULE6] status bits 4 and 0 always read zero
// [RULE7] the mode switches to the requested one; status confirms the switch (the code enters 100 for requests 101-111, and switches only while engine_idle)
// [RULE8] window select field uses the interrupt code encodings, copied by software
// [RULE9] writes to the status register are ignored
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
module cmsr_status
    import cmsr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // axi4-lite write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [AXI_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // protocol engine side
    input  wire logic [N_SRC-1:0]      irq_pending,
    input  wire logic                  engine_idle,
    output logic [2:0]                 operating_mode_status,
    output logic [2:0]                 interrupt_source_code,
    output logic [2:0]                 buffer_window_select,
    output logic                       abort_all_tx
);

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [AXI_DATA_W-1:0] rdata;
        logic                  aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_held;
        logic [AXI_DATA_W-1:0] w_data;
        logic [3:0]            w_strb;
        logic [2:0]            req_mode;
        logic                  abort_req;
        logic [2:0]            win_sel;
        cmsr_mode_t            opmode;
        logic [2:0]            icode;
    } cmsr_state_t;

    localparam cmsr_state_t ST_RESET = '{
        awready   : 1'b1,
        wready    : 1'b1,
        bvalid    : 1'b0,
        bresp     : RESP_OKAY,
        arready   : 1'b1,
        rvalid    : 1'b0,
        rresp     : RESP_OKAY,
        rdata     : '0,
        aw_held   : 1'b0,
        aw_addr   : '0,
        w_held    : 1'b0,
        w_data    : '0,
        w_strb    : '0,
        req_mode  : RST_REQ_MODE,
        abort_req : 1'b0,
        win_sel   : RST_WIN_SEL,
        opmode    : CMSR_MODE_CONFIG,
        icode     : CODE_NONE
    };

    cmsr_state_t            st;
    cmsr_state_t            next_st;
    logic [CODE_W-1:0]      enc_code;
    cmsr_mode_t             target_mode;
    logic                   wr_go;
    logic [AXI_ADDR_W-1:0]  wr_word;
    logic [AXI_ADDR_W-1:0]  rd_word;
    logic [REG_W-1:0]       ctrl_view;
    logic [REG_W-1:0]       stat_view;

    // prioritized source code
    cmsr_irq_encoder #(
        .NSRC (N_SRC),
        .CW   (CODE_W)
    ) u_enc (
        .pending (irq_pending),
        .code    (enc_code)
    );

    // any request with the top bit set means configuration
    always_comb
    begin
        if (st.req_mode[MODE_MSB-MODE_LSB])
        begin
            target_mode = CMSR_MODE_CONFIG;
        end
        else
        begin
            target_mode = cmsr_mode_t'(st.req_mode);
        end
    end

    assign wr_go   = st.aw_held && st.w_held && !st.bvalid;
    assign wr_word = {st.aw_addr[AXI_ADDR_W-1:2], 2'h0};
    assign rd_word = {s_axi_araddr[AXI_ADDR_W-1:2], 2'h0};

    // register views as read
    assign ctrl_view = {st.req_mode, st.abort_req, st.win_sel, 1'b0};
    assign stat_view = {st.opmode, 1'b0, st.icode, 1'b0}; // [RULE6]

    always_comb
    begin
        next_st = st;
        // write channels taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            if (wr_word == OFF_CONTROL)
            begin
                if (st.w_strb[0])
                begin
                    next_st.req_mode  = st.w_data[MODE_MSB:MODE_LSB];
                    next_st.abort_req = st.w_data[ABORT_BIT];
                    next_st.win_sel   = st.w_data[CODE_MSB:CODE_LSB]; // [RULE8]
                end
            end
            else if (wr_word == OFF_STATUS)
            begin
                next_st.bresp = RESP_OKAY; // [RULE9]
            end
            else
            begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;
        // read channel
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = '0;
            if (rd_word == OFF_CONTROL)
            begin
                next_st.rdata[REG_W-1:0] = ctrl_view;
            end
            else if (rd_word == OFF_STATUS)
            begin
                next_st.rdata[REG_W-1:0] = stat_view;
            end
            else
            begin
                next_st.rresp = RESP_SLVERR;
            end
        end
        next_st.arready = !next_st.rvalid;
        // mode entered once the engine is idle
        if (engine_idle && (st.opmode != target_mode))
        begin
            next_st.opmode = target_mode; // [RULE7] [RULE1]
        end
        next_st.icode = enc_code; // [RULE3] [RULE4] [RULE5]
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st <= ST_RESET; // [RULE2]
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs
    assign s_axi_awready         = st.awready;
    assign s_axi_wready          = st.wready;
    assign s_axi_bvalid          = st.bvalid;
    assign s_axi_bresp           = st.bresp;
    assign s_axi_arready         = st.arready;
    assign s_axi_rvalid          = st.rvalid;
    assign s_axi_rresp           = st.rresp;
    assign s_axi_rdata           = st.rdata;
    assign operating_mode_status = st.opmode;
    assign interrupt_source_code = st.icode;
    assign buffer_window_select  = st.win_sel;
    assign abort_all_tx          = st.abort_req;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_mode_legal: assert property ( // [RULE1]
        st.opmode inside {3'b000, 3'b001, 3'b010, 3'b011, 3'b100})
        else $error("reserved mode code reported");

    a_mode_reset: assert property ( // [RULE2]
        $rose(rst_n) |-> (operating_mode_status == 3'b100))
        else $error("mode not configuration after reset");

    a_code_pending: assert property ( // [RULE3]
        (irq_pending != '0) |=> (interrupt_source_code != 3'b000))
        else $error("pending interrupt not coded");

    a_code_wake: assert property ( // [RULE4]
        irq_pending[SRC_WAKE] |=> (interrupt_source_code == 3'b111))
        else $error("wake-up not top priority");

    a_code_error: assert property ( // [RULE5]
        (irq_pending == 7'h01) |=> (interrupt_source_code == 3'b001))
        else $error("error code wrong");

    a_code_none: assert property ( // [RULE5]
        (irq_pending == 7'h00) |=> (interrupt_source_code == 3'b000))
        else $error("idle code not zero");

    a_unimpl_zero: assert property ( // [RULE6]
        (s_axi_arvalid && s_axi_arready && (rd_word == OFF_STATUS))
        |=> (s_axi_rvalid && !s_axi_rdata[4] && !s_axi_rdata[0]))
        else $error("unimplemented status bit set");

    a_mode_follow: assert property ( // [RULE7]
        (engine_idle && (st.opmode != target_mode))
        |=> (operating_mode_status == ($past(st.req_mode[MODE_MSB-MODE_LSB])
            ? CMSR_MODE_CONFIG : cmsr_mode_t'($past(st.req_mode)))))
        else $error("mode request not followed");

    a_mode_hold: assert property ( // [RULE7]
        !engine_idle |=> $stable(operating_mode_status))
        else $error("mode changed while engine busy");

    a_win_copy: assert property ( // [RULE8]
        (wr_go && (wr_word == OFF_CONTROL) && st.w_strb[0])
        |=> (buffer_window_select == $past(st.w_data[CODE_MSB:CODE_LSB])) && s_axi_bvalid)
        else $error("window select not written");

    a_status_ro: assert property ( // [RULE9]
        (wr_go && (wr_word == OFF_STATUS) && !engine_idle)
        |=> $stable(st.opmode) && $stable(st.req_mode) && (s_axi_bresp == RESP_OKAY))
        else $error("status write changed state");

    a_bresp_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    a_code_highest: assert property ( // [RULE4]
        (irq_pending != '0)
        |=> (($past(irq_pending) >> (interrupt_source_code - 3'h1)) == 7'h01))
        else $error("code not highest pending source");

    a_rdata_hold: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    c_mode_switch: cover property (
        (st.opmode == CMSR_MODE_CONFIG) ##[1:20] (st.opmode == CMSR_MODE_NORMAL));

    c_status_read: cover property (
        s_axi_arvalid && s_axi_arready && (rd_word == OFF_STATUS));

    c_wake_code: cover property (
        interrupt_source_code == CODE_WAKE);

endmodule

// File: cmsr_status_tb.sv
// self-checking bench for the mode and interrupt code status block
// assumes cmsr_pkg compiled first; bench drives axi4-lite and engine inputs
module cmsr_status_tb
    import cmsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, abort_all_tx;
    logic [1:0]  bresp, rresp, r;
    logic [6:0]  irq_pending = 7'h00;
    logic        engine_idle = 1'b0;
    logic [2:0]  op_mode, icode, win_sel, cur_mode, win, m;
    logic [31:0] v, seed = 32'h1A03;
    int          err_total = 0;
    int          n_checks = 0;

    always #4 clk_sys = ~clk_sys;

    cmsr_status dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_pending(irq_pending),
        .engine_idle(engine_idle), .operating_mode_status(op_mode),
        .interrupt_source_code(icode), .buffer_window_select(win_sel),
        .abort_all_tx(abort_all_tx));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected priority code of a pending vector
    function automatic logic [2:0] enc(input logic [6:0] p);
        for (int i = 6; i >= 0; i--)
            if (p[i])
                return 3'(i + 1);
        return CODE_NONE;
    endfunction

    function automatic logic [31:0] stat(input logic [2:0] md, input logic [6:0] p);
        return {24'h0, md, 1'b0, enc(p), 1'b0};
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] rs);
        bit done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge clk_sys);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && !awvalid && !wvalid)
            begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
        begin
            $display("mismatch write response expected bvalid seen none");
            err_total++;
            stop_test();
        end
        else
        begin
            @(posedge clk_sys);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        bit done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge clk_sys);
            if (arvalid && arready)
                arvalid <= 1'b0;
            else if (rvalid && !arvalid)
            begin
                d = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
        begin
            $display("mismatch read response expected rvalid seen none");
            err_total++;
            stop_test();
        end
        else
        begin
            @(posedge clk_sys);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("mode after reset", 3'b100, op_mode);
        chk("code after reset", CODE_NONE, icode);
        chk("window after reset", RST_WIN_SEL, win_sel);
        chk("abort after reset", 1'b0, abort_all_tx);
        rd(OFF_STATUS, v, r);
        chk("status after reset", 32'h80, v);
        chk("status rresp", RESP_OKAY, r);
        rd(OFF_CONTROL, v, r);
        chk("control after reset", 32'h80, v);
        cur_mode = 3'b100;
        // every mode request, held off while the engine is busy
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            win = 3'(rnd());
            wr(OFF_CONTROL, {24'h0, m, 1'b0, win, 1'b0}, 4'hF, r);
            chk("control bresp", RESP_OKAY, r);
            repeat (2) @(posedge clk_sys);
            chk("mode held", cur_mode, op_mode);
            chk("window", win, win_sel);
            engine_idle <= 1'b1;
            repeat (2) @(posedge clk_sys);
            engine_idle <= 1'b0;
            cur_mode = m[2] ? 3'b100 : m;
            chk("mode switched", cur_mode, op_mode);
            rd(OFF_STATUS, v, r);
            chk("status mode", stat(cur_mode, 7'h0), v);
        end
        wr(OFF_CONTROL, 32'h10, 4'hF, r);
        @(posedge clk_sys);
        chk("abort level", 1'b1, abort_all_tx);
        wr(OFF_STATUS, 32'hFF, 4'hF, r);
        chk("status write resp", RESP_OKAY, r);
        rd(OFF_STATUS, v, r);
        chk("status after write", stat(cur_mode, 7'h0), v);
        rd(OFF_CONTROL, v, r);
        chk("control after status write", 32'h10, v);
        wr(OFF_CONTROL, 32'h0, 4'hF, r);
        chk("abort cleared", 1'b0, abort_all_tx);
        wr(OFF_CONTROL, 32'hFE, 4'hE, r);
        chk("masked bresp", RESP_OKAY, r);
        rd(OFF_CONTROL, v, r);
        chk("control after masked write", 32'h0, v);
        wr(8'h08, 32'h0, 4'hF, r);
        chk("unmapped bresp", RESP_SLVERR, r);
        rd(8'h0C, v, r);
        chk("unmapped rresp", RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, v);
        // single sources first, all at once, then random mixes
        for (int i = 0; i < 40; i++)
        begin
            v = (i < 7) ? (32'h1 << i) : ((i == 7) ? 32'h7F : rnd());
            irq_pending <= v[6:0];
            repeat (2) @(posedge clk_sys);
            chk("icode", enc(irq_pending), icode);
            rd(OFF_STATUS, v, r);
            chk("status code", stat(cur_mode, irq_pending), v);
        end
        irq_pending <= 7'h00;
        repeat (2) @(posedge clk_sys);
        chk("icode none", CODE_NONE, icode);
        stop_test();
    end
endmodule
